//--- vid_ctl_map.svh
// Purpose: register indices, field positions and reset values of the VID output control bank
// Assumes: included by the bank only; its synchroniser gets the reset value as a parameter
// Notes: definitions only
`ifndef VID_CTL_MAP_SVH
`define VID_CTL_MAP_SVH

`define IDX_FLY_CONFIG      8'h00
`define IDX_VID_MANUAL      8'h02
`define IDX_VID_SENSE       8'h04
`define IDX_OVC_A           8'h07
`define IDX_OVC_B           8'h08
`define IDX_OVC_C           8'h09
`define IDX_PIN_DRIVE       8'h0a
`define IDX_ADJUST_B        8'h0b
`define IDX_ADJUST_C        8'h0c
`define IDX_ADJUST_D        8'h0d
`define IDX_BOOST_INVERT    8'h0e

`define BIT_SWITCH_EN       7
`define BIT_OVERRIDE        6
`define BIT_SENSE_MODE      7
`define BIT_FLY_EN_B        6
`define BIT_SEL_EN_B        5
`define BIT_SEL_EN_A        4
`define BIT_FLY_EN_A        3
`define BIT_FLY_CHANGE      2

`define RST_LEVEL_CHOICE    4'h7
`define RST_OPEN_DRAIN      6'h3f
`define RST_INVERT          4'hf
`define RST_OVC_SPARE       2'h0
`define RST_SYNC_VEC        13'h1000

`endif

//--- vid_ctl_pkg.sv
// Purpose: shared types of the VID output control bank
// Assumes: nothing
// Notes: numbers live in vid_ctl_map.svh
`default_nettype none
package vid_ctl_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] level_t;
  typedef logic [5:0] vid_t;
endpackage
`default_nettype wire

//--- vid_pin_sync.sv
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: each bit is an independent slow level
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module vid_pin_sync #(
  parameter int          W       = 13,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         CLK,
  input  wire logic         RST_N,
  // levels
  input  wire logic [W-1:0] ASYNC_IN,
  output logic      [W-1:0] SYNC_OUT
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_chk
    $error("vid_pin_sync: width must be at least one");
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_q   <= RST_VAL;
      SYNC_OUT <= RST_VAL;
    end else begin
      meta_q   <= ASYNC_IN;
      SYNC_OUT <= meta_q;
    end
  end
endmodule // vid_pin_sync
`default_nettype wire

//--- vid_output_voltage_control.sv
// Purpose: register bank and steering for VID pass-through, level override and pin drive
// Assumes: one 100 MHz clock; pins and slot signal are asynchronous; watchdog pulse is on CLK
// Notes: read data stand one cycle after the read strobe and are zero otherwise
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "vid_ctl_map.svh"
module vid_output_voltage_control #(
  parameter int VID_W   = 6,
  parameter int LEVEL_W = 4
) (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               RST_N,
  // register port
  input  wire vid_ctl_pkg::byte_t ADDR,
  input  wire vid_ctl_pkg::byte_t WR_DATA,
  input  wire logic               WR_STB,
  input  wire logic               RD_STB,
  output vid_ctl_pkg::byte_t      RD_DATA,
  // analog level path
  input  wire vid_ctl_pkg::level_t ANALOG_CONTROL_INPUT,
  output vid_ctl_pkg::level_t     ANALOG_CONTROL_OUTPUT,
  // boost inputs and clear sources
  input  wire logic               BOOST_INPUT_A,
  input  wire logic               BOOST_INPUT_B,
  input  wire logic               SLOT_OCC_N,
  input  wire logic               WDT_TIMEOUT,
  // vid pins
  input  wire vid_ctl_pkg::vid_t  VID_PINS_I,
  output vid_ctl_pkg::vid_t       VID_PINS_O,
  output vid_ctl_pkg::vid_t       VID_PINS_OE,
  // resulting vid code
  output vid_ctl_pkg::vid_t       VID_CODE
);
  import vid_ctl_pkg::*;

  if (VID_W != 6 || LEVEL_W != 4) begin : g_chk
    $error("vid_output_voltage_control: only 6-bit VID and 4-bit levels are served");
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  function automatic logic hit(input byte_t a, input byte_t idx);
    return a == idx;
  endfunction

  // synchronised pins; a multi-bit code caught mid-change may show a mixed value for one cycle
  logic   [12:0] sync_vec;
  level_t ain_s;
  vid_t   pins_s;
  logic   boost_a_s;
  logic   boost_b_s;
  logic   slot_n_s;

  vid_pin_sync #(.W(13), .RST_VAL(`RST_SYNC_VEC)) u_sync (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .ASYNC_IN ({SLOT_OCC_N, BOOST_INPUT_B, BOOST_INPUT_A, VID_PINS_I, ANALOG_CONTROL_INPUT}),
    .SYNC_OUT (sync_vec)
  );
  assign ain_s     = sync_vec[3:0];
  assign pins_s    = sync_vec[9:4];
  assign boost_a_s = sync_vec[10];
  assign boost_b_s = sync_vec[11];
  assign slot_n_s  = sync_vec[12];

  // state
  logic       switch_en_q;
  logic       override_q;
  logic [1:0] ovc_spare_q;
  level_t     level_choice_q [4];
  vid_t       vid_pin_open_drain_mask_q;
  logic [1:0] drive_spare_q;
  vid_t       vid_adjust_q [1:3];
  logic [3:0] invert_q;
  logic       pin_fly_enable_b_q;
  logic       pin_select_enable_b_q;
  logic       pin_select_enable_a_q;
  logic       pin_fly_enable_a_q;
  logic       fly_change_enable_q;
  vid_t       vid_manual_q;
  logic       vid_sense_mode_q;
  vid_t       vid_latched_q;

  // decode
  wire clear_evt  = !slot_n_s || WDT_TIMEOUT;
  wire wr_cfg     = WR_STB && hit(ADDR, `IDX_FLY_CONFIG);
  wire wr_manual  = WR_STB && hit(ADDR, `IDX_VID_MANUAL);
  wire wr_sense   = WR_STB && hit(ADDR, `IDX_VID_SENSE);
  wire wr_ovc_a   = WR_STB && hit(ADDR, `IDX_OVC_A);
  wire wr_ovc_b   = WR_STB && hit(ADDR, `IDX_OVC_B);
  wire wr_ovc_c   = WR_STB && hit(ADDR, `IDX_OVC_C);
  wire wr_drive   = WR_STB && hit(ADDR, `IDX_PIN_DRIVE);
  wire wr_invert  = WR_STB && hit(ADDR, `IDX_BOOST_INVERT);
  wire [3:1] wr_adj = {WR_STB && hit(ADDR, `IDX_ADJUST_D),
                       WR_STB && hit(ADDR, `IDX_ADJUST_C),
                       WR_STB && hit(ADDR, `IDX_ADJUST_B)};

  // level choices and switch controls; the clear wins over a write in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      switch_en_q <= 1'b0;
      override_q  <= 1'b1;
      ovc_spare_q <= `RST_OVC_SPARE;
    end else if (clear_evt) begin
      switch_en_q <= 1'b0;
    end else if (wr_ovc_a) begin
      switch_en_q <= WR_DATA[`BIT_SWITCH_EN];
      override_q  <= WR_DATA[`BIT_OVERRIDE];
      ovc_spare_q <= WR_DATA[5:4];
    end
  end

  wire [3:0] wr_level = {wr_ovc_c, wr_ovc_b, wr_ovc_b, wr_ovc_a};
  wire level_t wr_level_val [4];
  assign wr_level_val[0] = WR_DATA[3:0];
  assign wr_level_val[1] = WR_DATA[3:0];
  assign wr_level_val[2] = WR_DATA[7:4];
  assign wr_level_val[3] = WR_DATA[3:0];

  for (genvar i = 0; i < 4; i++) begin : g_level
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        level_choice_q[i] <= `RST_LEVEL_CHOICE;
      end else if (clear_evt) begin
        level_choice_q[i] <= `RST_LEVEL_CHOICE;
      end else if (wr_level[i]) begin
        level_choice_q[i] <= wr_level_val[i];
      end
    end
  end

  // pin drive mask
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vid_pin_open_drain_mask_q <= `RST_OPEN_DRAIN;
      drive_spare_q             <= 2'h0;
    end else if (clear_evt) begin
      vid_pin_open_drain_mask_q <= `RST_OPEN_DRAIN;
    end else if (wr_drive) begin
      vid_pin_open_drain_mask_q <= WR_DATA[5:0];
      drive_spare_q             <= WR_DATA[7:6];
    end
  end

  // adjust offsets, never cleared by the slot or watchdog
  for (genvar j = 1; j <= 3; j++) begin : g_adj
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        vid_adjust_q[j] <= 6'h00;
      end else if (wr_adj[j]) begin
        vid_adjust_q[j] <= WR_DATA[5:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      invert_q <= `RST_INVERT;
    end else if (wr_invert) begin
      invert_q <= WR_DATA[3:0];
    end
  end

  // fly and pin-select enables
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      {pin_fly_enable_b_q, pin_select_enable_b_q, pin_select_enable_a_q} <= 3'h0;
      {pin_fly_enable_a_q, fly_change_enable_q}                          <= 2'h0;
    end else if (clear_evt) begin
      {pin_fly_enable_b_q, pin_select_enable_b_q, pin_select_enable_a_q} <= 3'h0;
      {pin_fly_enable_a_q, fly_change_enable_q}                          <= 2'h0;
    end else if (wr_cfg) begin
      pin_fly_enable_b_q    <= WR_DATA[`BIT_FLY_EN_B];
      pin_select_enable_b_q <= WR_DATA[`BIT_SEL_EN_B];
      pin_select_enable_a_q <= WR_DATA[`BIT_SEL_EN_A];
      pin_fly_enable_a_q    <= WR_DATA[`BIT_FLY_EN_A];
      fly_change_enable_q   <= WR_DATA[`BIT_FLY_CHANGE];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vid_manual_q <= 6'h00;
    end else if (wr_manual) begin
      vid_manual_q <= WR_DATA[5:0];
    end
  end

  // sense mode: a one-to-zero change freezes the pins it last saw
  wire sense_fall = wr_sense && vid_sense_mode_q && !WR_DATA[`BIT_SENSE_MODE];
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vid_sense_mode_q <= 1'b1;
    end else if (clear_evt) begin
      vid_sense_mode_q <= 1'b1;
    end else if (wr_sense) begin
      vid_sense_mode_q <= WR_DATA[`BIT_SENSE_MODE];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vid_latched_q <= 6'h00;
    end else if (sense_fall) begin
      vid_latched_q <= pins_s;
    end
  end

  // boost conditioning
  wire sel_a = pin_select_enable_a_q && (boost_a_s ^ invert_q[2]);
  wire sel_b = pin_select_enable_b_q && (boost_b_s ^ invert_q[3]);
  wire fly_a = fly_change_enable_q && pin_fly_enable_a_q && (boost_a_s ^ invert_q[0]);
  wire fly_b = fly_change_enable_q && pin_fly_enable_b_q && (boost_b_s ^ invert_q[1]);

  wire [1:0] level_idx  = {sel_b, sel_a};
  wire       use_choice = switch_en_q && override_q;
  // switch enable without override falls back to pass-through so the output never floats
  wire level_t level_d  = use_choice ? level_choice_q[level_idx] : ain_s;

  // fly adjustment: first input alone adds adjust 1, second alone adjust 2, both adjust 3
  wire [1:0] fly_idx    = {fly_b, fly_a};
  wire vid_t adjust_sel = (fly_idx == 2'h0) ? 6'h00 : vid_adjust_q[fly_idx];
  wire vid_t vid_code_d = vid_t'(vid_manual_q + adjust_sel);

  // open-drain bits only pull low; push-pull bits drive both levels
  wire vid_t pin_o_d;
  wire vid_t pin_oe_d;
  for (genvar k = 0; k < 6; k++) begin : g_pin
    assign pin_o_d[k]  = vid_pin_open_drain_mask_q[k] ? 1'b0 : vid_manual_q[k];
    assign pin_oe_d[k] = !vid_sense_mode_q &&
                         (!vid_pin_open_drain_mask_q[k] || !vid_manual_q[k]);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ANALOG_CONTROL_OUTPUT <= 4'h0;
      VID_CODE              <= 6'h00;
      VID_PINS_O            <= 6'h00;
      VID_PINS_OE           <= 6'h00;
    end else begin
      ANALOG_CONTROL_OUTPUT <= level_d;
      VID_CODE              <= vid_code_d;
      VID_PINS_O            <= pin_o_d;
      VID_PINS_OE           <= pin_oe_d;
    end
  end

  // read side
  wire vid_t sense_view = vid_sense_mode_q ? pins_s : vid_latched_q;
  byte_t rd_val;
  assign rd_val =
    hit(ADDR, `IDX_FLY_CONFIG) ? {1'b0, pin_fly_enable_b_q, pin_select_enable_b_q, pin_select_enable_a_q,
                                  pin_fly_enable_a_q, fly_change_enable_q, 2'h0} :
    hit(ADDR, `IDX_VID_MANUAL) ? {2'h0, vid_manual_q} :
    hit(ADDR, `IDX_VID_SENSE)  ? {vid_sense_mode_q, 1'b0, sense_view} :
    hit(ADDR, `IDX_OVC_A)      ? {switch_en_q, override_q, ovc_spare_q, level_choice_q[0]} :
    hit(ADDR, `IDX_OVC_B)      ? {level_choice_q[2], level_choice_q[1]} :
    hit(ADDR, `IDX_OVC_C)      ? {4'h0, level_choice_q[3]} :
    hit(ADDR, `IDX_PIN_DRIVE)  ? {drive_spare_q, vid_pin_open_drain_mask_q} :
    hit(ADDR, `IDX_ADJUST_B)   ? {2'h0, vid_adjust_q[1]} :
    hit(ADDR, `IDX_ADJUST_C)   ? {2'h0, vid_adjust_q[2]} :
    hit(ADDR, `IDX_ADJUST_D)   ? {2'h0, vid_adjust_q[3]} :
    hit(ADDR, `IDX_BOOST_INVERT) ? {4'h0, invert_q} : 8'h00;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= 8'h00;
    end else begin
      RD_DATA <= RD_STB ? rd_val : 8'h00;
    end
  end

  // checks
  wire    chk_sel_b = pin_select_enable_b_q && (boost_b_s ^ invert_q[3]);
  wire    chk_sel_a = pin_select_enable_a_q && (boost_a_s ^ invert_q[2]);
  level_t chk_level;
  assign  chk_level = level_choice_q[{chk_sel_b, chk_sel_a}];
  vid_t   chk_adj1;
  assign  chk_adj1  = vid_t'(vid_manual_q + vid_adjust_q[1]);

  sequence s_adj_write;
    WR_STB && ADDR == `IDX_ADJUST_B;
  endsequence
  sequence s_adj_read;
    RD_STB && ADDR == `IDX_ADJUST_B;
  endsequence
  sequence s_drive_held;
    (!vid_sense_mode_q && $stable(vid_manual_q) && $stable(vid_pin_open_drain_mask_q))[*2];
  endsequence

  property p_pass;
    !switch_en_q |=> ANALOG_CONTROL_OUTPUT == $past(ain_s);
  endproperty
  a_pass: assert property (p_pass) else $error("output did not follow input");
  property p_no_override;
    !override_q |=> ANALOG_CONTROL_OUTPUT == $past(ain_s);
  endproperty
  a_no_override: assert property (p_no_override) else $error("override off yet level forced");
  property p_choice;
    switch_en_q && override_q |=> ANALOG_CONTROL_OUTPUT == $past(chk_level);
  endproperty
  a_choice: assert property (p_choice) else $error("wrong level choice on output");
  property p_clear;
    clear_evt |=> !switch_en_q && vid_pin_open_drain_mask_q == `RST_OPEN_DRAIN
                  && level_choice_q[3] == `RST_LEVEL_CHOICE && !fly_change_enable_q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear event left fields set");
  property p_drive;
    s_drive_held |-> (VID_PINS_O & ~vid_pin_open_drain_mask_q) == (vid_manual_q & ~vid_pin_open_drain_mask_q)
                  && (VID_PINS_OE & vid_pin_open_drain_mask_q) == (~vid_manual_q & vid_pin_open_drain_mask_q);
  endproperty
  a_drive: assert property (p_drive) else $error("vid pins not driving manual value");
  property p_adjust;
    s_adj_write ##1 s_adj_read |=> RD_DATA == ($past(WR_DATA, 2) & 8'h3f);
  endproperty
  a_adjust: assert property (p_adjust) else $error("adjust readback wrong");
  property p_fly;
    fly_change_enable_q && pin_fly_enable_a_q && (boost_a_s ^ invert_q[0]) && !fly_b
      |=> VID_CODE == $past(chk_adj1);
  endproperty
  a_fly: assert property (p_fly) else $error("fly adjustment not applied");
  property p_latch;
    $fell(vid_sense_mode_q) && $past(RST_N) |-> vid_latched_q == $past(pins_s) ##1 VID_PINS_OE != 6'h00
      || vid_manual_q == 6'h3f;
  endproperty
  a_latch: assert property (p_latch) else $error("pins not latched on sense fall");
  property p_sense_hiz;
    vid_sense_mode_q |=> VID_PINS_OE == 6'h00;
  endproperty
  a_sense_hiz: assert property (p_sense_hiz) else $error("pins driven in sense mode");
endmodule // vid_output_voltage_control
`default_nettype wire

//--- vid_cpu_model.sv
// Purpose: processor side of the VID pins, resolving the shared wire level
// Assumes: open-drain pins see an external pull-up
// Notes: the processor drives its code only while told to
`timescale 1ns/1ns
`default_nettype none
module vid_cpu_model (
  // processor side
  input  wire logic              cpu_drive,
  input  wire vid_ctl_pkg::vid_t cpu_code,
  // device side
  input  wire vid_ctl_pkg::vid_t pin_o,
  input  wire vid_ctl_pkg::vid_t pin_oe,
  // resolved wire
  output vid_ctl_pkg::vid_t      pin_wire
);
  import vid_ctl_pkg::*;
  // a released pin floats up, so a stale value never survives the hand-over
  vid_t far_level;
  assign far_level = cpu_drive ? cpu_code : 6'h3f;
  assign pin_wire  = (pin_oe & pin_o) | (~pin_oe & far_level);
endmodule // vid_cpu_model
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench of the VID output control bank
// Assumes: pins resolved by the processor model, 100 MHz clock
// Notes: registers reached through one-cycle strobes only
`timescale 1ns/1ns
`default_nettype none
module tb;
  import vid_ctl_pkg::*;
  logic   clk       = 1'b0;
  logic   rst_n     = 1'b0;
  byte_t  addr      = 8'h00;
  byte_t  wdata     = 8'h00;
  logic   wr        = 1'b0;
  logic   rd        = 1'b0;
  byte_t  rdata;
  level_t ain       = 4'h5;
  level_t aout;
  logic   ba        = 1'b0;
  logic   bb        = 1'b0;
  logic   slot_n    = 1'b1;
  logic   wdt       = 1'b0;
  logic   cpu_drive = 1'b1;
  vid_t   pins;
  vid_t   pin_o;
  vid_t   pin_oe;
  vid_t   code;
  int     err_total = 0;
  int     samples_checked = 0;
  int     cycles    = 0;
  byte_t  ra [11]   = '{8'h00, 8'h02, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h30};
  byte_t  rv [11]   = '{8'h00, 8'h00, 8'h47, 8'h77, 8'h07, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00};
  level_t ch [4]    = '{4'h1, 4'h2, 4'h3, 4'h4};
  vid_t   adj [4]   = '{6'h00, 6'h03, 6'h3e, 6'h01};

  vid_output_voltage_control DUT (
    .CLK                   (clk),
    .RST_N                 (rst_n),
    .ADDR                  (addr),
    .WR_DATA               (wdata),
    .WR_STB                (wr),
    .RD_STB                (rd),
    .RD_DATA               (rdata),
    .ANALOG_CONTROL_INPUT  (ain),
    .ANALOG_CONTROL_OUTPUT (aout),
    .BOOST_INPUT_A         (ba),
    .BOOST_INPUT_B         (bb),
    .SLOT_OCC_N            (slot_n),
    .WDT_TIMEOUT           (wdt),
    .VID_PINS_I            (pins),
    .VID_PINS_O            (pin_o),
    .VID_PINS_OE           (pin_oe),
    .VID_CODE              (code)
  );

  vid_cpu_model cpu (
    .cpu_drive (cpu_drive),
    .cpu_code  (6'h15),
    .pin_o     (pin_o),
    .pin_oe    (pin_oe),
    .pin_wire  (pins)
  );

  always #5 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic check(input string name, input byte_t seen, input byte_t exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input byte_t a, input byte_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input byte_t a, input byte_t exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rdata, exp);
  endtask

  // write then read back with no idle cycle between the strobes
  task automatic wr_rd(input byte_t a, input byte_t d, input byte_t exp);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    rd    <= 1'b1;
    @(posedge clk);
    rd    <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rdata, exp);
  endtask

  // walks all boost combinations; flip is what the invert bits do to them
  task automatic steer(input logic [1:0] flip, input logic fly);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ba <= i[0];
      bb <= i[1];
      idle(5);
      if (fly) begin
        check("vid code", {2'h0, code}, {2'h0, 6'h2a + adj[i[1:0] ^ flip]});
      end else begin
        check("level out", {4'h0, aout}, {4'h0, ch[i[1:0] ^ flip]});
      end
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    idle(4);
    for (int i = 0; i < 11; i++) rd_reg(ra[i], rv[i]);
    rd_reg(8'h04, 8'h95);
    check("level pass", {4'h0, aout}, 8'h05);
    wr_rd(8'h0b, 8'hff, 8'h3f);
    wr_reg(8'h30, 8'hff);
    rd_reg(8'h30, 8'h00);
    $display("test registers done");

    wr_reg(8'h07, 8'hc1);
    wr_reg(8'h08, 8'h32);
    wr_reg(8'h09, 8'h04);
    wr_reg(8'h00, 8'h30);
    steer(2'h3, 1'b0);
    wr_reg(8'h0e, 8'h00);
    steer(2'h0, 1'b0);
    wr_reg(8'h07, 8'h81);
    idle(2);
    check("override off", {4'h0, aout}, 8'h05);
    $display("test level done");

    wr_reg(8'h02, 8'h2a);
    wr_reg(8'h0a, 8'h0f);
    #1;
    check("oe sensing", {2'h0, pin_oe}, 8'h00);
    wr_reg(8'h04, 8'h00);
    @(posedge clk);
    cpu_drive <= 1'b0;
    idle(3);
    check("pin oe", {2'h0, pin_oe}, 8'h35);
    check("pin wire", {2'h0, pins}, 8'h2a);
    rd_reg(8'h04, 8'h15);
    $display("test pins done");

    wr_reg(8'h0b, 8'h03);
    wr_reg(8'h0c, 8'h3e);
    wr_reg(8'h0d, 8'h01);
    wr_reg(8'h0e, 8'h03);
    wr_reg(8'h00, 8'h4c);
    steer(2'h3, 1'b1);
    wr_reg(8'h0e, 8'h00);
    steer(2'h0, 1'b1);
    $display("test fly done");

    // a write landing while the clear is active must lose
    wr_reg(8'h07, 8'hc1);
    @(posedge clk);
    slot_n    <= 1'b0;
    cpu_drive <= 1'b1;
    idle(3);
    wr_reg(8'h08, 8'h12);
    @(posedge clk);
    slot_n <= 1'b1;
    idle(4);
    for (int i = 2; i < 6; i++) rd_reg(ra[i], rv[i]);
    rd_reg(8'h00, 8'h00);
    rd_reg(8'h04, 8'h95);
    check("oe cleared", {2'h0, pin_oe}, 8'h00);
    wr_reg(8'h07, 8'hc1);
    @(posedge clk);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    rd_reg(8'h07, 8'h47);
    $display("test clear done");
    close_out();
  end
endmodule // tb
`default_nettype wire
